// ===== uart_chan_pkg.sv
// constants shared by the serial channel data path
// assumes a 16x/8x sampling enable supplied by an external rate generator
package uart_chan_pkg;
  localparam int          FIFO_DEPTH      = 64;
  localparam int          PTR_W           = 6;
  localparam int          CNT_W           = 7;
  localparam int          RX_ENTRY_W      = 11;
  localparam logic [4:0]  OSR_16X         = 5'h10;
  localparam logic [4:0]  OSR_8X          = 5'h08;
  localparam logic [3:0]  MID_16X         = 4'h8;
  localparam logic [3:0]  MID_8X          = 4'h4;
  localparam logic [4:0]  IR_PULSE_16X    = 5'h03;
  localparam int          TMO_CHARS       = 4;
  localparam int          TMO_EXTRA_BITS  = 12;
  localparam int          CHAR_BITS_BASE  = 7;
  localparam logic        MCR_IR_RESET    = 1'b0;
  typedef enum logic [1:0] {
    TX_IDLE  = 2'b00,
    TX_START = 2'b01,
    TX_DATA  = 2'b10,
    TX_STOP  = 2'b11
  } tx_state_t;
  typedef enum logic [1:0] {
    RX_IDLE  = 2'b00,
    RX_START = 2'b01,
    RX_DATA  = 2'b10,
    RX_STOP  = 2'b11
  } rx_state_t;
endpackage : uart_chan_pkg

// ===== uart_chan_buf.sv
// two-entry valid/ready buffer in the receive data path
// assumes a single clock; both sides may stall freely
`timescale 1ns/10ps
module uart_chan_buf #(
  parameter int W = 11
) (
  input  wire logic         sys_clk_i,
  input  wire logic         rstn_i,
  input  wire logic [W-1:0] in_data_i,
  input  wire logic         in_valid_i,
  output logic              in_ready_o,
  output logic [W-1:0]      out_data_o,
  output logic              out_valid_o,
  input  wire logic         out_ready_i
);
  logic [W-1:0] slot_r [2];
  logic [1:0]   cnt_r;
  logic         rd_r;
  logic         wr_r;
  logic         push;
  logic         pop;

  assign in_ready_o  = (cnt_r != 2'h2);
  assign out_valid_o = (cnt_r != 2'h0);
  assign out_data_o  = slot_r[rd_r];
  assign push        = in_valid_i && in_ready_o;
  assign pop         = out_valid_o && out_ready_i;

  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      cnt_r <= 2'h0;
      rd_r  <= 1'b0;
      wr_r  <= 1'b0;
    end else begin
      if (push) wr_r <= ~wr_r;
      if (pop) rd_r <= ~rd_r;
      cnt_r <= cnt_r + {1'b0, push} - {1'b0, pop};
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (push) slot_r[wr_r] <= in_data_i;
  end
endmodule : uart_chan_buf

// ===== uart_chan.sv
// one serial channel: tx fifo/shifter, rx sampler/fifo, flow, rs485, infrared
// assumes samp_en_i pulses once per sampling clock; control bits are ports
`timescale 1ns/10ps
// Functional notes
// - transmit fifo accepts up to 64 host bytes in fifo mode
// - holding-empty status set whenever transmit fifo is empty
// - tx empty interrupt on drop below trigger outside rs485 mode and on empty, if enabled
// - shifter-empty status set only after final stop bit is out
// - rs485 mode sources tx empty interrupt from shifter empty
// - rs485 direction high while sending, low after programmed delay
// - start validated at half bit outside ir mode; data and stop sampled mid-bit
// - error flags follow the byte at the fifo head after each read
// - rx data interrupt per character or at trigger level, if enabled
// - time-out after four characters plus twelve bits with data held, at any fifo level
// - receive fifo holds 64 entries of 11 bits
// - holding register is the fifo output stage when fifos enabled
// - select rts/cts or dtr/dsr; separate auto output and input enables
// - flow pin de-assert interrupts need enhanced bit and enables
// - cts high halts after current stop bit, sets status; resumes low
// - auto rts drops at upper threshold, returns at lower threshold
// - infrared start-up pin sampled at reset release into ir mode bit
// - infrared mode blocks receiver while transmitter is busy
// - infrared tx idles low; low rx input is idle
// - infrared encoder sends 3/16 bit pulse per zero bit, 1/8 bit in 8x mode
// - decoder gives zero per pulse; optional input inversion
// - bit period is 16 or 8 sampling clocks
module uart_chan
  import uart_chan_pkg::*;
(
  input  wire logic       sys_clk_i,
  input  wire logic       rstn_i,
  input  wire logic       samp_en_i,
  input  wire logic       mode_8x_i,
  input  wire logic       fifo_en_i,
  input  wire logic [1:0] word_len_i,
  input  wire logic [5:0] tx_trigger_level_i,
  input  wire logic [5:0] rx_trigger_level_i,
  input  wire logic       rx_trig_mode_i,
  input  wire logic [6:0] rts_hi_thr_i,
  input  wire logic [6:0] rts_lo_thr_i,
  input  wire logic [7:0] int_enable_i,
  input  wire logic       rs485_en_i,
  input  wire logic [3:0] rs485_delay_i,
  input  wire logic       dtr_dsr_sel_i,
  input  wire logic       auto_rts_en_i,
  input  wire logic       auto_cts_en_i,
  input  wire logic       enh_en_i,
  input  wire logic       rts_bit_i,
  input  wire logic       dtr_bit_i,
  input  wire logic       ir_mode_wr_i,
  input  wire logic       ir_mode_val_i,
  input  wire logic       ir_rx_inv_i,
  input  wire logic       ir_startup_pin_i,
  input  wire logic [7:0] tx_holding_reg_i,
  input  wire logic       tx_wr_i,
  input  wire logic       rx_rd_i,
  input  wire logic       int_status_rd_i,
  input  wire logic       rx_pin_i,
  input  wire logic       cts_n_i,
  input  wire logic       dsr_n_i,
  output logic            tx_pin_o,
  output logic            rts_n_o,
  output logic            dtr_n_o,
  output logic [7:0]      rx_holding_reg_o,
  output logic [7:0]      line_status_reg_o,
  output logic [7:0]      int_status_reg_o,
  output logic [6:0]      tx_level_o,
  output logic [6:0]      rx_level_o,
  output logic            ir_mode_o
);
  function automatic logic [5:0] ptr_inc(input logic [5:0] p);
    ptr_inc = p + 6'h01;
  endfunction : ptr_inc

  // three-stage synchronisers; a change counts when stages two and three agree
  logic [2:0] rx_s_r;
  logic [2:0] cts_s_r;
  logic [2:0] dsr_s_r;
  logic [2:0] irp_s_r;
  logic       rx_f_r;
  logic       cts_f_r;
  logic       dsr_f_r;
  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rx_s_r  <= 3'h7;
      cts_s_r <= 3'h7;
      dsr_s_r <= 3'h7;
      rx_f_r  <= 1'b1;
      cts_f_r <= 1'b1;
      dsr_f_r <= 1'b1;
    end else begin
      rx_s_r  <= {rx_s_r[1:0], rx_pin_i};
      cts_s_r <= {cts_s_r[1:0], cts_n_i};
      dsr_s_r <= {dsr_s_r[1:0], dsr_n_i};
      if (rx_s_r[1] == rx_s_r[2]) rx_f_r <= rx_s_r[2];
      if (cts_s_r[1] == cts_s_r[2]) cts_f_r <= cts_s_r[2];
      if (dsr_s_r[1] == dsr_s_r[2]) dsr_f_r <= dsr_s_r[2];
    end
  end

  always_ff @(posedge sys_clk_i) irp_s_r <= {irp_s_r[1:0], ir_startup_pin_i};
  // strap caught on the first clock after reset release
  logic ir_mode_r;
  logic strap_done_r;
  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      ir_mode_r    <= MCR_IR_RESET;
      strap_done_r <= 1'b0;
    end else if (!strap_done_r) begin
      strap_done_r <= 1'b1;
      ir_mode_r    <= irp_s_r[2];
    end else if (ir_mode_wr_i) begin
      ir_mode_r <= ir_mode_val_i;
    end
  end
  assign ir_mode_o = ir_mode_r;

  logic [4:0] osr;
  logic [3:0] mid;
  assign osr = mode_8x_i ? OSR_8X : OSR_16X;
  assign mid = mode_8x_i ? MID_8X : MID_16X;

  // ---------------- transmit fifo
  logic [7:0]  tx_mem [FIFO_DEPTH];
  logic [5:0]  tx_rd_r;
  logic [5:0]  tx_wr_r;
  logic [6:0]  tx_cnt_r;
  logic        tx_pop;
  logic        tx_push;
  logic        tx_cap;
  assign tx_cap  = fifo_en_i ? (tx_cnt_r < 7'(FIFO_DEPTH)) : (tx_cnt_r == 7'h0);
  assign tx_push = tx_wr_i && tx_cap;
  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      tx_rd_r  <= 6'h00;
      tx_wr_r  <= 6'h00;
      tx_cnt_r <= 7'h00;
    end else begin
      if (tx_push) tx_wr_r <= ptr_inc(tx_wr_r);
      if (tx_pop) tx_rd_r <= ptr_inc(tx_rd_r);
      tx_cnt_r <= tx_cnt_r + {6'h00, tx_push} - {6'h00, tx_pop};
    end
  end
  always_ff @(posedge sys_clk_i) begin
    if (tx_push) tx_mem[tx_wr_r] <= tx_holding_reg_i;
  end
  assign tx_level_o = tx_cnt_r;

  // ---------------- transmitter
  tx_state_t  tx_st_r;
  logic [4:0] tx_tick_r;
  logic [2:0] tx_bit_r;
  logic [7:0] tx_sh_r;
  logic       tx_line_r;
  logic       cts_halt;
  logic       flow_in;
  logic       tx_bit_end;
  logic [2:0] last_bit;
  assign flow_in    = dtr_dsr_sel_i ? dsr_f_r : cts_f_r;
  assign cts_halt   = auto_cts_en_i && flow_in;
  assign tx_bit_end = samp_en_i && (tx_tick_r == osr - 5'h01);
  assign last_bit   = 3'(CHAR_BITS_BASE - 3) + {1'b0, word_len_i};
  assign tx_pop     = (tx_st_r == TX_IDLE) && (tx_cnt_r != 7'h0) && !cts_halt;
  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      tx_st_r   <= TX_IDLE;
      tx_tick_r <= 5'h00;
      tx_bit_r  <= 3'h0;
      tx_sh_r   <= 8'h00;
      tx_line_r <= 1'b1;
    end else begin
      if (samp_en_i) tx_tick_r <= tx_bit_end ? 5'h00 : tx_tick_r + 5'h01;
      case (tx_st_r)
        TX_IDLE: begin
          tx_line_r <= 1'b1;
          if (tx_pop) begin
            tx_sh_r   <= tx_mem[tx_rd_r];
            tx_st_r   <= TX_START;
            tx_tick_r <= 5'h00;
            tx_line_r <= 1'b0;
          end
        end
        TX_START: if (tx_bit_end) begin
          tx_st_r   <= TX_DATA;
          tx_bit_r  <= 3'h0;
          tx_line_r <= tx_sh_r[0];
        end
        TX_DATA: if (tx_bit_end) begin
          tx_sh_r <= {1'b0, tx_sh_r[7:1]};
          if (tx_bit_r == last_bit) begin
            tx_st_r   <= TX_STOP;
            tx_line_r <= 1'b1;
          end else begin
            tx_bit_r  <= tx_bit_r + 3'h1;
            tx_line_r <= tx_sh_r[1];
          end
        end
        TX_STOP: if (tx_bit_end) tx_st_r <= TX_IDLE;
        default: tx_st_r <= TX_IDLE;
      endcase
    end
  end

  logic tsr_empty;
  logic thr_empty;
  assign tsr_empty = (tx_st_r == TX_IDLE) && (tx_cnt_r == 7'h0);
  assign thr_empty = (tx_cnt_r == 7'h0);

  // infrared encoder: 3/16 pulse, scaled by half in 8x mode
  logic [4:0] ir_w;
  logic       tx_busy;
  assign ir_w    = mode_8x_i ? (IR_PULSE_16X >> 1) : IR_PULSE_16X;
  assign tx_busy = (tx_st_r != TX_IDLE);
  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      tx_pin_o <= 1'b1;
    end else if (ir_mode_r) begin
      tx_pin_o <= tx_busy && !tx_line_r && (tx_tick_r < ir_w);
    end else begin
      tx_pin_o <= tx_line_r;
    end
  end

  // ---------------- rs485 turnaround, counted in bit periods
  logic [3:0] ta_cnt_r;
  logic       dir_r;
  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      dir_r    <= 1'b0;
      ta_cnt_r <= 4'h0;
    end else if (tx_busy) begin
      dir_r    <= 1'b1;
      ta_cnt_r <= rs485_delay_i;
    end else if (dir_r) begin
      if (ta_cnt_r == 4'h0) dir_r <= 1'b0;
      else if (tx_bit_end) ta_cnt_r <= ta_cnt_r - 4'h1;
    end
  end

  // ---------------- receiver
  logic rx_in;
  logic rx_ir;
  assign rx_ir = rx_f_r ^ ir_rx_inv_i;
  assign rx_in = ir_mode_r ? !rx_ir : rx_f_r;
  rx_state_t  rx_st_r;
  logic [4:0] rx_tick_r;
  logic [2:0] rx_bit_r;
  logic [7:0] rx_sh_r;
  logic       rx_par_r;
  logic       rx_ir_hit_r;
  logic       rx_in_d_r;
  logic       rx_samp;
  logic       rx_bit;
  logic       rx_vld;
  logic [10:0] rx_word;
  logic        buf_rdy;
  logic        rx_blocked;
  assign rx_blocked = ir_mode_r && tx_busy;
  assign rx_samp = samp_en_i && (rx_tick_r == {1'b0, mid} - 5'h01);
  // in ir mode a pulse up to the mid-bit sample counts as a zero
  assign rx_bit  = ir_mode_r ? (rx_in && !rx_ir_hit_r) : rx_in;
  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rx_st_r     <= RX_IDLE;
      rx_tick_r   <= 5'h00;
      rx_bit_r    <= 3'h0;
      rx_sh_r     <= 8'h00;
      rx_par_r    <= 1'b0;
      rx_ir_hit_r <= 1'b0;
      rx_in_d_r   <= 1'b1;
      rx_vld      <= 1'b0;
      rx_word     <= 11'h000;
    end else begin
      rx_vld <= 1'b0;
      rx_in_d_r <= rx_in;
      if (samp_en_i) begin
        rx_tick_r <= (rx_tick_r == osr - 5'h01) ? 5'h00 : rx_tick_r + 5'h01;
        if (rx_tick_r == osr - 5'h01) rx_ir_hit_r <= 1'b0;
        else if (!rx_in) rx_ir_hit_r <= 1'b1;
      end
      case (rx_st_r)
        RX_IDLE: if (!rx_in && rx_in_d_r && !rx_blocked) begin
          rx_st_r     <= RX_START;
          rx_tick_r   <= 5'h00;
          rx_ir_hit_r <= 1'b0;
        end
        RX_START: if (rx_samp) begin
          rx_bit_r <= 3'h0;
          rx_st_r  <= (ir_mode_r || !rx_in) ? RX_DATA : RX_IDLE;
        end
        RX_DATA: if (rx_samp) begin
          rx_sh_r <= {rx_bit, rx_sh_r[7:1]};
          if (rx_bit_r == last_bit) rx_st_r <= RX_STOP;
          else rx_bit_r <= rx_bit_r + 3'h1;
        end
        RX_STOP: if (rx_samp) begin
          rx_st_r <= RX_IDLE;
          rx_vld  <= 1'b1;
          // flags: break(4) framing(3) overrun(2) beside the byte
          rx_word <= {(rx_sh_r == 8'h00) && !rx_bit, !rx_bit, !buf_rdy,
                      rx_sh_r >> (3'h3 - {1'b0, word_len_i})};
        end
        default: rx_st_r <= RX_IDLE;
      endcase
    end
  end

  // ---------------- rx buffer then rx fifo
  logic [10:0] bo_data;
  logic        bo_vld;
  logic        rx_push;
  logic [10:0] rx_mem [FIFO_DEPTH];
  logic [5:0]  rx_rd_r;
  logic [5:0]  rx_wr_r;
  logic [6:0]  rx_cnt_r;
  logic        rx_cap;
  logic        rx_pop;
  assign rx_cap  = fifo_en_i ? (rx_cnt_r < 7'(FIFO_DEPTH)) : (rx_cnt_r == 7'h0);
  assign rx_push = bo_vld && rx_cap;
  assign rx_pop  = rx_rd_i && (rx_cnt_r != 7'h0);
  uart_chan_buf #(.W(RX_ENTRY_W)) u_rx_buf (
    .sys_clk_i   (sys_clk_i),
    .rstn_i      (rstn_i),
    .in_data_i   (rx_word),
    .in_valid_i  (rx_vld),
    .in_ready_o  (buf_rdy),
    .out_data_o  (bo_data),
    .out_valid_o (bo_vld),
    .out_ready_i (rx_cap)
  );
  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rx_rd_r  <= 6'h00;
      rx_wr_r  <= 6'h00;
      rx_cnt_r <= 7'h00;
    end else begin
      if (rx_push) rx_wr_r <= ptr_inc(rx_wr_r);
      if (rx_pop) rx_rd_r <= ptr_inc(rx_rd_r);
      rx_cnt_r <= rx_cnt_r + {6'h00, rx_push} - {6'h00, rx_pop};
    end
  end
  always_ff @(posedge sys_clk_i) begin
    if (rx_push) rx_mem[rx_wr_r] <= bo_data;
  end
  logic [10:0] rx_head;
  assign rx_head = rx_mem[rx_rd_r];
  // head entry drives the error flags directly and the holding register one cycle later
  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) rx_holding_reg_o <= 8'h00;
    else if (rx_cnt_r != 7'h0) rx_holding_reg_o <= rx_head[7:0];
  end
  assign rx_level_o = rx_cnt_r;
  assign line_status_reg_o = {1'b0, tsr_empty, thr_empty,
                              rx_head[10:8] & {3{rx_cnt_r != 7'h0}}, 1'b0,
                              rx_cnt_r != 7'h0};

  // ---------------- time-out: 4 characters plus 12 bits, in bit periods
  logic [6:0] tmo_lim;
  logic [6:0] tmo_r;
  logic       tmo_fire_r;
  assign tmo_lim = 7'(TMO_CHARS) * (7'(CHAR_BITS_BASE) + {5'h00, word_len_i})
                   + 7'(TMO_EXTRA_BITS);
  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      tmo_r      <= 7'h00;
      tmo_fire_r <= 1'b0;
    end else if (rx_cnt_r == 7'h0 || rx_push || rx_pop) begin
      tmo_r      <= 7'h00;
      tmo_fire_r <= 1'b0;
    end else if (tx_bit_end && tmo_r != tmo_lim) begin
      tmo_r <= tmo_r + 7'h01;
    end else if (tmo_r == tmo_lim) begin
      tmo_fire_r <= 1'b1;
    end
  end

  // ---------------- auto rts/dtr output with hysteresis
  logic flow_out_r;
  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) flow_out_r <= 1'b1;
    else if (rx_cnt_r >= rts_hi_thr_i) flow_out_r <= 1'b0;
    else if (rx_cnt_r <= rts_lo_thr_i) flow_out_r <= 1'b1;
  end
  logic sel_bit;
  logic auto_out_n;
  logic out_n;
  assign sel_bit    = dtr_dsr_sel_i ? dtr_bit_i : rts_bit_i;
  assign auto_out_n = !(sel_bit && (!auto_rts_en_i || flow_out_r));
  assign out_n      = rs485_en_i ? dir_r : auto_out_n;
  assign rts_n_o    = dtr_dsr_sel_i ? !rts_bit_i : out_n;
  assign dtr_n_o    = dtr_dsr_sel_i ? out_n : !dtr_bit_i;

  // ---------------- interrupt sources
  logic rx_trig;
  logic tx_below;
  logic tx_below_d_r;
  logic tx_empt_src_d_r;
  logic tx_int_r;
  logic flow_in_d_r;
  logic out_n_d_r;
  logic cts_int_r;
  logic rts_int_r;
  logic tx_empt_src;
  assign rx_trig     = rx_trig_mode_i ? (rx_cnt_r >= {1'b0, rx_trigger_level_i})
                                      : (rx_cnt_r != 7'h0);
  assign tx_below    = tx_cnt_r < {1'b0, tx_trigger_level_i};
  assign tx_empt_src = rs485_en_i ? tsr_empty : thr_empty;
  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      tx_below_d_r    <= 1'b1;
      tx_empt_src_d_r <= 1'b1;
      tx_int_r        <= 1'b0;
      flow_in_d_r     <= 1'b1;
      out_n_d_r       <= 1'b1;
      cts_int_r       <= 1'b0;
      rts_int_r       <= 1'b0;
    end else begin
      tx_below_d_r    <= tx_below;
      tx_empt_src_d_r <= tx_empt_src;
      flow_in_d_r     <= flow_in;
      out_n_d_r       <= out_n;
      // set wins over the clear on the same cycle
      if ((tx_below && !tx_below_d_r && !rs485_en_i) ||
          (tx_empt_src && !tx_empt_src_d_r)) tx_int_r <= 1'b1;
      else if (tx_wr_i || int_status_rd_i) tx_int_r <= 1'b0;
      if (enh_en_i && int_enable_i[7] && flow_in && !flow_in_d_r)
        cts_int_r <= 1'b1;
      else if (int_status_rd_i) cts_int_r <= 1'b0;
      if (enh_en_i && int_enable_i[6] && out_n && !out_n_d_r)
        rts_int_r <= 1'b1;
      else if (int_status_rd_i) rts_int_r <= 1'b0;
    end
  end
  assign int_status_reg_o = {2'h0, cts_int_r || rts_int_r, 1'b0,
                             int_enable_i[0] && tmo_fire_r,
                             int_enable_i[0] && rx_trig,
                             int_enable_i[1] && tx_int_r, 1'b0};
endmodule : uart_chan

// ===== uart_chan_assertions.sv
// port-level checks for the serial channel, bound into uart_chan
// assumes one clock; samp_en_i pulses once per sampling tick
`timescale 1ns/10ps
module uart_chan_assertions (
  input wire logic       sys_clk_i,
  input wire logic       rstn_i,
  input wire logic       samp_en_i,
  input wire logic       mode_8x_i,
  input wire logic       fifo_en_i,
  input wire logic       rx_trig_mode_i,
  input wire logic [6:0] rts_hi_thr_i,
  input wire logic [7:0] int_enable_i,
  input wire logic       rs485_en_i,
  input wire logic       dtr_dsr_sel_i,
  input wire logic       auto_rts_en_i,
  input wire logic       auto_cts_en_i,
  input wire logic       rts_bit_i,
  input wire logic       cts_n_i,
  input wire logic       tx_pin_o,
  input wire logic       rts_n_o,
  input wire logic [7:0] line_status_reg_o,
  input wire logic [7:0] int_status_reg_o,
  input wire logic [6:0] tx_level_o,
  input wire logic [6:0] rx_level_o,
  input wire logic       ir_mode_o
);
  logic [3:0] ir_hi_r;
  logic [7:0] cts_hi_r;
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!rstn_i);
  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) ir_hi_r <= 4'h0;
    else if (!tx_pin_o || !ir_mode_o) ir_hi_r <= 4'h0;
    else if (samp_en_i && ir_hi_r != 4'hf) ir_hi_r <= ir_hi_r + 4'h1;
  end
  // 255 ticks is well past one frame, so the current character is done
  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) cts_hi_r <= 8'h00;
    else if (!auto_cts_en_i || !cts_n_i || dtr_dsr_sel_i)
      cts_hi_r <= 8'h00;
    else if (samp_en_i && cts_hi_r != 8'hff) cts_hi_r <= cts_hi_r + 8'h01;
  end
  a_tx_cap: assert property (tx_level_o <= 7'h40)
    else $error("tx level above depth");
  a_thr_empty: assert property (fifo_en_i && tx_level_o == 7'h00
    |-> line_status_reg_o[5]) else $error("holding empty flag low");
  a_tsr_busy: assert property (!tx_pin_o && $past(!tx_pin_o)
    && !ir_mode_o |-> !line_status_reg_o[6]) else $error("shifter empty early");
  a_ir_idle: assert property (ir_mode_o && $past(ir_mode_o)
    && line_status_reg_o[6] && $past(line_status_reg_o[6]) |-> !tx_pin_o)
    else $error("ir line not idle low");
  a_ir_width: assert property (ir_mode_o && !mode_8x_i
    |-> ir_hi_r <= 4'h3) else $error("ir pulse too wide");
  a_dir_high: assert property (rs485_en_i && !dtr_dsr_sel_i
    && !ir_mode_o && !tx_pin_o && $past(!tx_pin_o) |-> rts_n_o)
    else $error("direction low while sending");
  a_cts_halt: assert property (cts_hi_r == 8'hff
    |-> !$fell(tx_pin_o)) else $error("start bit sent while halted");
  a_rx_ready: assert property (fifo_en_i && rx_level_o != 7'h00
    |-> ##[0:1] line_status_reg_o[0]) else $error("data ready missing");
  a_rx_irq: assert property (int_enable_i[0] && !rx_trig_mode_i
    && line_status_reg_o[0] && $past(line_status_reg_o[0], 2)
    |-> int_status_reg_o[2]) else $error("rx data irq missing");
  a_irq_mask: assert property (!int_enable_i[1]
    |-> !int_status_reg_o[1]) else $error("tx irq while disabled");
  a_rts_drop: assert property (auto_rts_en_i && rts_bit_i
    && !rs485_en_i && !dtr_dsr_sel_i && rx_level_o >= rts_hi_thr_i
    |-> ##[0:2] rts_n_o) else $error("rts not dropped at threshold");
  c_ir_pulse: cover property (ir_hi_r == 4'h3);
  c_cts_halt: cover property (cts_hi_r == 8'hff);
  c_rts_drop: cover property (auto_rts_en_i && rts_n_o);
endmodule : uart_chan_assertions
bind uart_chan uart_chan_assertions i_uart_chan_assertions (.*);

// ===== uart_far.sv
// remote serial end: sends frames to the channel, decodes its output
// assumes 8 data bits, one stop bit, BIT_CYC clocks per bit
`timescale 1ns/10ps
module uart_far #(
  parameter int BIT_CYC = 32
) (
  input  wire logic       sys_clk_i,
  input  wire logic       line_i,
  input  wire logic       listen_i,
  output logic            line_o,
  output logic [8:0]      got_o,
  output logic            got_stb_o
);
  initial begin
    line_o = 1'b1;
    got_o = 9'h000;
    got_stb_o = 1'b0;
  end
  task automatic send(input logic [7:0] b, input logic stop);
    logic [9:0] f;
    f = {stop, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      #1 line_o = f[i];
      repeat (BIT_CYC) @(posedge sys_clk_i);
    end
    #1 line_o = 1'b1;
  endtask : send
  // stop level is kept in bit 8 so framing on the wire is checked too
  always begin
    @(negedge line_i iff listen_i);
    repeat (BIT_CYC / 2) @(posedge sys_clk_i);
    for (int i = 0; i < 9; i++) begin
      repeat (BIT_CYC) @(posedge sys_clk_i);
      got_o[i] = line_i;
    end
    #1 got_stb_o = 1'b1;
    @(posedge sys_clk_i);
    #1 got_stb_o = 1'b0;
  end
endmodule : uart_far

// ===== uart_chan_tb.sv
// self-checking bench for uart_chan with a remote serial end
// assumes a sampling tick every other clock, so a bit is 32 clocks
`timescale 1ns/10ps
module uart_chan_tb
  import uart_chan_pkg::*;
;
  localparam int BIT = 32;
  logic sys_clk_i = 1'b0, rstn_i = 1'b0, samp_en_i = 1'b0;
  logic mode_8x_i = 1'b0, fifo_en_i = 1'b1, rx_trig_mode_i = 1'b0;
  logic rs485_en_i = 1'b0, dtr_dsr_sel_i = 1'b0, auto_rts_en_i = 1'b0;
  logic auto_cts_en_i = 1'b1, enh_en_i = 1'b0, rts_bit_i = 1'b0;
  logic dtr_bit_i = 1'b0, ir_mode_wr_i = 1'b0, ir_mode_val_i = 1'b0;
  logic ir_rx_inv_i = 1'b0, ir_startup_pin_i = 1'b0, tx_wr_i = 1'b0;
  logic rx_rd_i = 1'b0, int_status_rd_i = 1'b0, cts_n_i = 1'b1;
  logic dsr_n_i = 1'b1, drain = 1'b0, listen = 1'b1;
  logic tx_pin_o, rts_n_o, dtr_n_o, ir_mode_o, rx_pin_i, got_stb;
  logic [1:0]  word_len_i = 2'h3;
  logic [3:0]  rs485_delay_i = 4'h0;
  logic [5:0]  tx_trigger_level_i = 6'h00, rx_trigger_level_i = 6'h00;
  logic [6:0]  rts_hi_thr_i = 7'h00, rts_lo_thr_i = 7'h00;
  logic [6:0]  tx_level_o, rx_level_o;
  logic [7:0]  int_enable_i = 8'hc3, tx_holding_reg_i = 8'h00;
  logic [7:0]  rx_holding_reg_o, line_status_reg_o, int_status_reg_o;
  logic [8:0]  got;
  logic [15:0] txq[$], rxq[$];
  int          fails = 0, tests_run = 0;
  uart_chan i_uart_chan (.*);
  uart_far #(.BIT_CYC(BIT)) i_uart_far (
    .sys_clk_i(sys_clk_i),
    .line_i   (tx_pin_o),
    .listen_i (listen),
    .line_o   (rx_pin_i),
    .got_o    (got),
    .got_stb_o(got_stb)
  );
  always #50 sys_clk_i = ~sys_clk_i;
  always @(posedge sys_clk_i) #1 samp_en_i = ~samp_en_i;
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      fails++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic finish_test();
    $display("checks %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : finish_test
  function automatic logic done(input int c);
    case (c)
      0: return line_status_reg_o[6] && tx_level_o == 7'h00;
      1: return rx_level_o == 7'h00;
      default: return 1'b0;
    endcase
  endfunction : done
  task automatic wait_until(input int c);
    int k;
    for (k = 0; k < 30000 && done(c) !== 1'b1; k++) @(posedge sys_clk_i);
    #1;
    if (k == 30000) begin
      fails++;
      finish_test();
    end
  endtask : wait_until
  task automatic burst(input int n, input int keep);
    tx_wr_i = 1'b1;
    for (int i = 0; i < n; i++) begin
      tx_holding_reg_i = 8'($urandom);
      if (i < keep) txq.push_back({8'h01, tx_holding_reg_i});
      @(posedge sys_clk_i);
      #1;
    end
    tx_wr_i = 1'b0;
  endtask : burst
  task automatic feed(input int n, input logic bad);
    logic [7:0] b;
    for (int i = 0; i < n; i++) begin
      b = 8'($urandom) | 8'h01;
      rxq.push_back({7'h00, bad && i == n - 1, b});
      i_uart_far.send(b, !(bad && i == n - 1));
    end
  endtask : feed
  always @(posedge sys_clk_i) if (got_stb)
    check(16'(got), txq.size() ? txq.pop_front() : 16'hdead);
  // holding register trails the fifo head by one cycle
  always @(posedge sys_clk_i) if (drain && line_status_reg_o[0] === 1'b1) begin
    @(posedge sys_clk_i);
    #1 check({7'h00, line_status_reg_o[3], rx_holding_reg_o},
      rxq.size() ? rxq.pop_front() : 16'hdead);
    rx_rd_i = 1'b1;
    @(posedge sys_clk_i);
    #1 rx_rd_i = 1'b0;
    @(posedge sys_clk_i);
  end
  initial begin
    void'($urandom(72));
    tx_trigger_level_i = 6'($urandom);
    ir_rx_inv_i = 1'($urandom);
    repeat (20) @(posedge sys_clk_i);
    #1 rstn_i = 1'b1;
    enh_en_i = 1'b1;
    repeat (2) @(posedge sys_clk_i);
    #1 check(16'(line_status_reg_o[6:5]), 16'h3);
    check(16'(ir_mode_o), 16'h0);
    burst(FIFO_DEPTH + 1, FIFO_DEPTH);
    check(16'(tx_level_o), 16'(FIFO_DEPTH));
    repeat (600) @(posedge sys_clk_i);
    #1 check(16'(tx_level_o), 16'(FIFO_DEPTH));
    cts_n_i = 1'b0;
    repeat (5 * BIT) @(posedge sys_clk_i);
    #1 cts_n_i = 1'b1;
    repeat (700) @(posedge sys_clk_i);
    #1 check(16'(int_status_reg_o[5]), 16'h1);
    cts_n_i = 1'b0;
    wait_until(0);
    check(16'(int_status_reg_o[1]), 16'h1);
    check(16'(line_status_reg_o[6:5]), 16'h3);
    int_status_rd_i = 1'b1;
    @(posedge sys_clk_i);
    #1 int_status_rd_i = 1'b0;
    check(16'(int_status_reg_o[1]), 16'h0);
    drain = 1'b1;
    feed(3, 1'b1);
    repeat (BIT) @(posedge sys_clk_i);
    wait_until(1);
    drain = 1'b0;
    rts_hi_thr_i = 7'h08;
    rts_lo_thr_i = 7'h02;
    auto_rts_en_i = 1'b1;
    rts_bit_i = 1'b1;
    dtr_bit_i = 1'b1;
    feed(8, 1'b0);
    repeat (BIT) @(posedge sys_clk_i);
    #1 check(16'(rts_n_o), 16'h1);
    check(16'(dtr_n_o), 16'h0);
    drain = 1'b1;
    wait_until(1);
    check(16'(rts_n_o), 16'h0);
    auto_rts_en_i = 1'b0;
    drain = 1'b0;
    rx_trig_mode_i = 1'b1;
    rx_trigger_level_i = 6'h08;
    feed(1, 1'b0);
    repeat (40 * BIT) @(posedge sys_clk_i);
    #1 check(16'(int_status_reg_o[3]), 16'h0);
    repeat (16 * BIT) @(posedge sys_clk_i);
    #1 check(16'(int_status_reg_o[3]), 16'h1);
    drain = 1'b1;
    rx_trig_mode_i = 1'b0;
    wait_until(1);
    rs485_en_i = 1'b1;
    rs485_delay_i = 4'h2;
    burst(1, 1);
    repeat (3 * BIT) @(posedge sys_clk_i);
    #1 check(16'(int_status_reg_o[1]), 16'h0);
    wait_until(0);
    check(16'({rts_n_o, int_status_reg_o[1]}), 16'h3);
    repeat (3 * BIT) @(posedge sys_clk_i);
    #1 check(16'(rts_n_o), 16'h0);
    rs485_en_i = 1'b0;
    check(16'(txq.size() + rxq.size()), 16'h0);
    drain = 1'b0;
    listen = 1'b0;
    ir_mode_val_i = 1'b1;
    ir_mode_wr_i = 1'b1;
    @(posedge sys_clk_i);
    #1 ir_mode_wr_i = 1'b0;
    repeat (2) @(posedge sys_clk_i);
    #1 check(16'({ir_mode_o, tx_pin_o}), 16'h2);
    burst(2, 0);
    wait_until(0);
    ir_startup_pin_i = 1'b1;
    rstn_i = 1'b0;
    repeat (3) @(posedge sys_clk_i);
    #1 rstn_i = 1'b1;
    repeat (3) @(posedge sys_clk_i);
    #1 check(16'(ir_mode_o), 16'h1);
    finish_test();
  end
endmodule : uart_chan_tb
